// ===== verilog/mr_params.svh
/*
  Constants of the large dual-port RAM block: geometry, lane layout and reset values.
  Assumes it is included by bare name from the package and the design modules.
*/
`ifndef MR_PARAMS_SVH
`define MR_PARAMS_SVH

`define MR_DATA_W     72
`define MR_ADDR_W     16
`define MR_LANES      8
`define MR_LANE_W     9
`define MR_ARR_AW     13
`define MR_DEPTH      14'h2000
`define MR_TOTAL_BITS 20'h90000
`define MR_CNT_W      14
`define MR_CNT_ZERO   14'h0000
`define MR_PTR_ONE    13'h0001
`define MR_PTR_ZERO   13'h0000

`endif

// ===== verilog/mr_pkg.sv
/*
  Types shared by the large dual-port RAM block and its array.
  Assumes mr_params.svh is on the include path.
*/
`include "mr_params.svh"

package mr_pkg;

  typedef enum logic [1:0] {
    MR_MODE_TRUE_DP,
    MR_MODE_SIMPLE_DP,
    MR_MODE_SINGLE,
    MR_MODE_FIFO
  } mr_mode_t;

  typedef struct packed {
    logic in_sel;
    logic out_sel;
    logic bypass;
  } mr_port_cfg_t;

  typedef struct packed {
    logic                     renwe;
    logic [`MR_ADDR_W-1:0]    addr;
    logic [`MR_LANES-1:0]     be;
    logic [`MR_DATA_W-1:0]    din;
  } mr_port_req_t;

endpackage

// ===== verilog/mr_array.sv
/*
  Storage array of the RAM block: two synchronous ports, nine-bit byte lanes, registered read data.
  Assumes all inputs come from registers on ref_clk; contents are never reset or preloaded.
*/
`timescale 1ns/1ps
`default_nettype none

`include "mr_params.svh"

module mr_array
  import mr_pkg::*;
(
  input  wire logic                  ref_clk,  // Block clock.
  input  wire logic                  en_a,     // Port A access this edge.
  input  wire logic                  we_a,     // Port A write.
  input  wire logic [`MR_ARR_AW-1:0] addr_a,   // Port A word address.
  input  wire logic [`MR_LANES-1:0]  be_a,     // Port A lane enables.
  input  wire logic [`MR_DATA_W-1:0] din_a,    // Port A write data.
  output var  logic [`MR_DATA_W-1:0] q_a,      // Port A read data.
  input  wire logic                  en_b,     // Port B access this edge.
  input  wire logic                  we_b,     // Port B write.
  input  wire logic [`MR_ARR_AW-1:0] addr_b,   // Port B word address.
  input  wire logic [`MR_LANES-1:0]  be_b,     // Port B lane enables.
  input  wire logic [`MR_DATA_W-1:0] din_b,    // Port B write data.
  output var  logic [`MR_DATA_W-1:0] q_b       // Port B read data.
);

  // Each lane is its own array so a disabled lane keeps its old contents.
  // A read that meets a write on the same edge returns the old word.
  for (genvar l = 0; l < `MR_LANES; l++) begin : g_lane
    logic [`MR_LANE_W-1:0] mem [`MR_DEPTH];
    always_ff @(posedge ref_clk) begin
      if (en_a && we_a && be_a[l]) begin
        mem[addr_a] <= din_a[l*`MR_LANE_W +: `MR_LANE_W];
      end
      // Same address written by both ports leaves port B's data; the array gives no arbitration.
      if (en_b && we_b && be_b[l]) begin
        mem[addr_b] <= din_b[l*`MR_LANE_W +: `MR_LANE_W];
      end
      if (en_a) begin
        q_a[l*`MR_LANE_W +: `MR_LANE_W] <= mem[addr_a];
      end
      if (en_b) begin
        q_b[l*`MR_LANE_W +: `MR_LANE_W] <= mem[addr_b];
      end
    end
  end

endmodule

`default_nettype wire

// ===== verilog/mr_ram_block.sv
/*
  Large embedded dual-port RAM block: 8K x 72 array with per-port input registers,
  optional output registers, address hold, lane enables and four operating modes.
  Assumes one clock ref_clk; the per-port clock enables stand for the two port clocks,
  and all user inputs come from logic on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

`include "mr_params.svh"

module mr_ram_block
  import mr_pkg::*;
(
  input  wire logic                  ref_clk,     // Block clock, 125 MHz.
  input  wire logic                  rst,         // Synchronous reset, active high.
  input  wire mr_mode_t              mode,        // Operating mode.
  input  wire mr_port_cfg_t          cfg_a,       // Port A clock selects and bypass.
  input  wire mr_port_cfg_t          cfg_b,       // Port B clock selects and bypass.
  input  wire logic                  clocken_a,   // Port A clock strobe.
  input  wire logic                  clocken_b,   // Port B clock strobe.
  input  wire logic                  addr_ena_a,  // Port A address enable.
  input  wire logic                  addr_ena_b,  // Port B address enable.
  input  wire logic                  clr_a,       // Port A output clear.
  input  wire logic                  clr_b,       // Port B output clear.
  input  wire mr_port_req_t          req_a,       // Port A request bundle.
  input  wire mr_port_req_t          req_b,       // Port B request bundle.
  output var  logic [`MR_DATA_W-1:0] dataout_a,   // Port A read data.
  output var  logic [`MR_DATA_W-1:0] dataout_b,   // Port B read data.
  output var  logic                  fifo_full,   // FIFO has no free word.
  output var  logic                  fifo_empty   // FIFO holds no word.
);

  logic [1:0]            clk_en;
  mr_port_cfg_t          cfg     [2];
  mr_port_req_t          req     [2];
  logic [1:0]            addr_ena;
  logic [1:0]            clr;
  logic [1:0]            in_stb;
  logic [1:0]            out_stb;
  logic [1:0]            port_on;
  logic                  push;
  logic                  pop;

  mr_port_req_t          in_reg    [2];
  mr_port_req_t          in_next   [2];
  logic [1:0]            go_reg;
  logic [1:0]            go_next;
  logic [`MR_DATA_W-1:0] q         [2];
  logic [`MR_DATA_W-1:0] pipe_reg  [2];
  logic [`MR_DATA_W-1:0] pipe_next [2];
  logic [`MR_DATA_W-1:0] out_reg   [2];
  logic [`MR_DATA_W-1:0] out_next  [2];

  logic [`MR_ARR_AW-1:0] wptr_reg;
  logic [`MR_ARR_AW-1:0] wptr_next;
  logic [`MR_ARR_AW-1:0] rptr_reg;
  logic [`MR_ARR_AW-1:0] rptr_next;
  logic [`MR_CNT_W-1:0]  cnt_reg;
  logic [`MR_CNT_W-1:0]  cnt_next;
  logic                  full_reg;
  logic                  full_next;
  logic                  empty_reg;
  logic                  empty_next;

  assign clk_en   = {clocken_b, clocken_a};
  assign cfg[0]   = cfg_a;
  assign cfg[1]   = cfg_b;
  assign req[0]   = req_a;
  assign req[1]   = req_b;
  assign addr_ena = {addr_ena_b, addr_ena_a};
  assign clr      = {clr_b, clr_a};

  // Each register group follows whichever port strobe its select names.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      in_stb[p]  = clk_en[cfg[p].in_sel];
      out_stb[p] = clk_en[cfg[p].out_sel];
    end
  end

  // Single-port mode retires port B; the other modes keep both ports alive.
  assign port_on = {mode != MR_MODE_SINGLE, 1'b1};

  // FIFO: port A pushes, port B pops; requests against full or empty are dropped.
  assign push = (mode == MR_MODE_FIFO) && in_stb[0] && req_a.renwe && !full_reg;
  assign pop  = (mode == MR_MODE_FIFO) && in_stb[1] && req_b.renwe && !empty_reg;

  always_comb begin
    wptr_next  = push ? wptr_reg + `MR_PTR_ONE : wptr_reg;
    rptr_next  = pop ? rptr_reg + `MR_PTR_ONE : rptr_reg;
    cnt_next   = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + `MR_CNT_W'(1);
    end else if (pop && !push) begin
      cnt_next = cnt_reg - `MR_CNT_W'(1);
    end
    full_next  = (cnt_next == `MR_DEPTH);
    empty_next = (cnt_next == `MR_CNT_ZERO);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wptr_reg  <= `MR_PTR_ZERO;
      rptr_reg  <= `MR_PTR_ZERO;
      cnt_reg   <= `MR_CNT_ZERO;
      full_reg  <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      cnt_reg   <= cnt_next;
      full_reg  <= full_next;
      empty_reg <= empty_next;
    end
  end

  // Input registers: every request field but the address is latched on its port strobe; the address also needs addr_ena.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      in_next[p] = in_reg[p];
      go_next[p] = 1'b0;
      if (in_stb[p] && port_on[p]) begin
        in_next[p].renwe = req[p].renwe;
        in_next[p].be    = req[p].be;
        in_next[p].din   = req[p].din;
        if (addr_ena[p]) begin
          in_next[p].addr = req[p].addr;
        end
        go_next[p] = 1'b1;
      end
      unique case (mode)
        MR_MODE_SIMPLE_DP: begin
          if (p == 1) begin
            in_next[p].renwe = 1'b0;
          end else begin
            in_next[p].renwe = 1'b1;
          end
        end
        MR_MODE_FIFO: begin
          if (p == 0) begin
            in_next[p].addr  = `MR_ADDR_W'(wptr_reg);
            in_next[p].renwe = 1'b1;
            go_next[p]       = push;
          end else begin
            in_next[p].addr  = `MR_ADDR_W'(rptr_reg);
            in_next[p].renwe = 1'b0;
            go_next[p]       = pop;
          end
        end
        MR_MODE_TRUE_DP, MR_MODE_SINGLE: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      in_reg[0] <= '0;
      in_reg[1] <= '0;
      go_reg    <= 2'h0;
    end else begin
      in_reg[0] <= in_next[0];
      in_reg[1] <= in_next[1];
      go_reg    <= go_next;
    end
  end

  // Only the low address bits index the 72-bit array; narrow word shapes are not offered.
  mr_array u_array (
    .ref_clk (ref_clk),
    .en_a    (go_reg[0]),
    .we_a    (in_reg[0].renwe),
    .addr_a  (in_reg[0].addr[`MR_ARR_AW-1:0]),
    .be_a    (in_reg[0].be),
    .din_a   (in_reg[0].din),
    .q_a     (q[0]),
    .en_b    (go_reg[1]),
    .we_b    (in_reg[1].renwe),
    .addr_b  (in_reg[1].addr[`MR_ARR_AW-1:0]),
    .be_b    (in_reg[1].be),
    .din_b   (in_reg[1].din),
    .q_b     (q[1])
  );

  // The pin stage always registers so outputs come from flops; bypass skips the output register.
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pipe_next[p] = out_stb[p] ? q[p] : pipe_reg[p];
      out_next[p]  = cfg[p].bypass ? q[p] : pipe_reg[p];
      if (clr[p]) begin
        pipe_next[p] = '0;
        out_next[p]  = '0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pipe_reg[0] <= '0;
      pipe_reg[1] <= '0;
      out_reg[0]  <= '0;
      out_reg[1]  <= '0;
    end else begin
      pipe_reg[0] <= pipe_next[0];
      pipe_reg[1] <= pipe_next[1];
      out_reg[0]  <= out_next[0];
      out_reg[1]  <= out_next[1];
    end
  end

  assign dataout_a  = out_reg[0];
  assign dataout_b  = out_reg[1];
  assign fifo_full  = full_reg;
  assign fifo_empty = empty_reg;

endmodule

`default_nettype wire

// ===== sim/mr_ram_block_checker.sv
/* Port assertions of the RAM block.
   Assumes a bind into mr_ram_block and one clock. */
`timescale 1ns/1ps
`default_nettype none
module mr_ram_block_checker
  import mr_pkg::*;
(
  input wire logic         ref_clk,    // Clock.
  input wire logic         rst,        // Reset.
  input wire mr_mode_t     mode,       // Mode.
  input wire mr_port_cfg_t cfg_a,      // A setup.
  input wire mr_port_cfg_t cfg_b,      // B setup.
  input wire logic         clocken_a,  // A strobe.
  input wire logic         clocken_b,  // B strobe.
  input wire logic         clr_a,      // A clear.
  input wire logic         clr_b,      // B clear.
  input wire mr_port_req_t req_a,      // A request.
  input wire logic [71:0]  dataout_a,  // A data.
  input wire logic [71:0]  dataout_b,  // B data.
  input wire logic         fifo_full,  // Full.
  input wire logic         fifo_empty  // Empty.
);
  logic push;
  // Port A's input side follows whichever strobe its select names, as the block does.
  assign push = mode == MR_MODE_FIFO && (cfg_a.in_sel ? clocken_b : clocken_a) && req_a.renwe;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A setup change may reshuffle the output stages, so idle demands it holds.
  sequence idle;
    !clocken_a && !clocken_b && !clr_a && !clr_b && $stable({mode, cfg_a, cfg_b});
  endsequence
  a_reset_data_zero: assert property (
    $fell(rst) |-> dataout_a == '0 && dataout_b == '0) else $error("data set at reset");
  a_reset_flags_set: assert property (
    $fell(rst) |-> fifo_empty && !fifo_full) else $error("flags wrong at reset");
  a_clear_a_zero: assert property (
    clr_a |=> dataout_a == '0) else $error("port A not cleared");
  a_clear_b_zero: assert property (
    clr_b |=> dataout_b == '0) else $error("port B not cleared");
  a_flags_apart: assert property (
    !(fifo_full && fifo_empty)) else $error("full and empty together");
  a_idle_holds_a: assert property (
    idle [*4] |=> $stable(dataout_a)) else $error("port A moved while idle");
  a_idle_holds_b: assert property (
    idle [*4] |=> $stable(dataout_b)) else $error("port B moved while idle");
  a_push_fills: assert property (
    push && fifo_empty |-> ##[1:3] !fifo_empty) else $error("push left fifo empty");
endmodule
bind mr_ram_block mr_ram_block_checker chk_i (
  .ref_clk    (ref_clk),
  .rst        (rst),
  .mode       (mode),
  .cfg_a      (cfg_a),
  .cfg_b      (cfg_b),
  .clocken_a  (clocken_a),
  .clocken_b  (clocken_b),
  .clr_a      (clr_a),
  .clr_b      (clr_b),
  .req_a      (req_a),
  .dataout_a  (dataout_a),
  .dataout_b  (dataout_b),
  .fifo_full  (fifo_full),
  .fifo_empty (fifo_empty)
);
`default_nettype wire

// ===== sim/mr_user_logic.sv
/* User logic model that drives both ports of the RAM block.
   Assumes the bench calls its tasks; all changes land at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module mr_user_logic
  import mr_pkg::*;
(
  input  wire logic         ref_clk,     // Clock.
  output var  logic         clocken_a,   // A strobe.
  output var  logic         clocken_b,   // B strobe.
  output var  logic         addr_ena_a,  // A address enable.
  output var  logic         addr_ena_b,  // B address enable.
  output var  logic         clr_a,       // A clear.
  output var  logic         clr_b,       // B clear.
  output var  mr_port_req_t req_a,       // A request.
  output var  mr_port_req_t req_b        // B request.
);
  initial begin
    {clocken_a, clocken_b, addr_ena_a, addr_ena_b, clr_a, clr_b} = 6'h00;
    req_a = '0;
    req_b = '0;
  end
  // Released request lines are inverted so a late sample sees junk, not a lucky repeat.
  task automatic hit(input logic b, input mr_port_req_t r, input logic ae);
    @(negedge ref_clk);
    if (b) begin
      req_b = r;
      addr_ena_b = ae;
      clocken_b = 1'b1;
    end else begin
      req_a = r;
      addr_ena_a = ae;
      clocken_a = 1'b1;
    end
    @(negedge ref_clk);
    clocken_a = 1'b0;
    clocken_b = 1'b0;
    req_a = ~req_a;
    req_b = ~req_b;
  endtask
  task automatic clear(input logic b);
    @(negedge ref_clk);
    clr_a = !b;
    clr_b = b;
    @(negedge ref_clk);
    clr_a = 1'b0;
    clr_b = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sim/mr_ram_block_tb.sv
/* Self-checking bench of the RAM block.
   Assumes mr_user_logic drives the ports and the checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
module mr_ram_block_tb
  import mr_pkg::*;
;
  localparam logic [71:0] d0 = 72'h123456789ABCDEF012;
  localparam logic [71:0] d1 = 72'hFEDCBA9876543210ED;
  logic         ref_clk, rst, clocken_a, clocken_b, addr_ena_a, addr_ena_b, clr_a, clr_b;
  logic         fifo_full, fifo_empty;
  logic [71:0]  dataout_a, dataout_b;
  mr_mode_t     mode;
  mr_port_cfg_t cfg_a, cfg_b;
  mr_port_req_t req_a, req_b;
  int           errors, total_checks, cyc;
  mr_user_logic ul (
    .ref_clk    (ref_clk),
    .clocken_a  (clocken_a),
    .clocken_b  (clocken_b),
    .addr_ena_a (addr_ena_a),
    .addr_ena_b (addr_ena_b),
    .clr_a      (clr_a),
    .clr_b      (clr_b),
    .req_a      (req_a),
    .req_b      (req_b)
  );
  mr_ram_block  dut (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .mode       (mode),
    .cfg_a      (cfg_a),
    .cfg_b      (cfg_b),
    .clocken_a  (clocken_a),
    .clocken_b  (clocken_b),
    .addr_ena_a (addr_ena_a),
    .addr_ena_b (addr_ena_b),
    .clr_a      (clr_a),
    .clr_b      (clr_b),
    .req_a      (req_a),
    .req_b      (req_b),
    .dataout_a  (dataout_a),
    .dataout_b  (dataout_b),
    .fifo_full  (fifo_full),
    .fifo_empty (fifo_empty)
  );
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Filling and draining the whole FIFO takes about 33k cycles.
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [71:0] exp, input logic [71:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [71:0] merge(input logic [71:0] o, n, input logic [7:0] be);
    for (int l = 0; l < 8; l++) if (be[l]) o[9*l +: 9] = n[9*l +: 9];
    return o;
  endfunction
  task automatic wr(input logic b, input logic [15:0] a, input logic [7:0] be, input logic [71:0] d);
    ul.hit(b, '{1'b1, a, be, d}, 1'b1);
  endtask
  task automatic rd(input logic b, input logic [15:0] a, input logic ae);
    ul.hit(b, '{1'b0, a, 8'hFF, 72'h0}, ae);
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic do_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
  endtask
  task automatic t_reset();
    chk("dataout_a", '0, dataout_a);
    chk("dataout_b", '0, dataout_b);
    chk("fifo_full", '0, fifo_full);
    $display("test reset done");
  endtask
  task automatic t_lanes();
    cfg_a = '{1'b0, 1'b0, 1'b1};
    cfg_b = '{1'b1, 1'b1, 1'b1};
    wr(0, 16'h0010, 8'hFF, d0);
    wr(0, 16'h0010, 8'h55, d1);
    wr(1, 16'h0020, 8'hFF, d1);
    rd(1, 16'h0010, 1);
    chk("lanes on B", merge(d0, d1, 8'h55), dataout_b);
    rd(0, 16'h0020, 0);
    chk("held address on A", merge(d0, d1, 8'h55), dataout_a);
    $display("test lanes done");
  endtask
  task automatic t_outreg();
    // With bypass on, the pin stage reloads the array output right after a clear, so both ports register here.
    cfg_a = '{1'b0, 1'b1, 1'b0};
    cfg_b = '{1'b1, 1'b1, 1'b0};
    ul.clear(0);
    ul.clear(1);
    @(negedge ref_clk);
    chk("cleared A", '0, dataout_a);
    chk("cleared B", '0, dataout_b);
    rd(0, 16'h0020, 1);
    chk("A before B strobe", '0, dataout_a);
    rd(1, 16'h0010, 1);
    chk("A after B strobe", d1, dataout_a);
    $display("test output register done");
  endtask
  task automatic t_modes();
    cfg_a = '{1'b0, 1'b0, 1'b1};
    cfg_b = '{1'b1, 1'b1, 1'b1};
    mode = MR_MODE_SIMPLE_DP;
    wr(0, 16'h0030, 8'hFF, d0);
    rd(1, 16'h0030, 1);
    wr(1, 16'h0030, 8'hFF, d1);
    // A fresh read is needed: the old word would also show if the blocked write had landed.
    rd(1, 16'h0030, 1);
    chk("B forced to read", d0, dataout_b);
    mode = MR_MODE_SINGLE;
    wr(1, 16'h0030, 8'hFF, d1);
    rd(0, 16'h0030, 1);
    chk("B ignored in single", d0, dataout_a);
    $display("test modes done");
  endtask
  task automatic t_fifo();
    do_reset();
    chk("fifo_empty", 72'h1, fifo_empty);
    mode = MR_MODE_FIFO;
    for (int i = 0; i < 8193; i++) wr(0, 16'h0, 8'hFF, 72'(i));
    repeat (2) @(negedge ref_clk);
    chk("fifo_full", 72'h1, fifo_full);
    for (int i = 0; i < 8192; i++) begin
      ul.hit(1, '{1'b1, 16'h0, 8'hFF, 72'h0}, 1'b1);
      if (i < 2 || i == 8191) begin
        repeat (3) @(negedge ref_clk);
        chk("popped word", 72'(i), dataout_b);
      end
    end
    chk("fifo_empty", 72'h1, fifo_empty);
    $display("test fifo done");
  endtask
  initial begin
    rst = 1'b1;
    mode = MR_MODE_TRUE_DP;
    cfg_a = '0;
    cfg_b = '0;
    do_reset();
    t_reset();
    t_lanes();
    t_outreg();
    t_modes();
    t_fifo();
    finish_test();
  end
endmodule
`default_nettype wire
